// ---- rtl/pdd_pkg.sv ----
// pdd_pkg: constants for the dual fly-by dma engine.
// assumes a single system clock; no register bus, all config is plain ports.
package pdd_pkg;
	// ==========================================================
	// channel structure
	localparam int NUM_CH = 8;
	localparam int CASCADE_CH = 4;
	localparam int FIRST_WIDE_CH = 5;
	localparam int ADDR_W = 26;
	localparam int CNT_W = 16;
	localparam int PAGE_W = 8;
	localparam int EXT_W = 2;
	// ==========================================================
	// mode field encodings
	localparam logic [1:0] MODE_DEMAND = 2'h0;
	localparam logic [1:0] MODE_SINGLE = 2'h1;
	localparam logic [1:0] MODE_BLOCK = 2'h2;
	localparam logic [1:0] MODE_CASCADE = 2'h3;
	localparam logic [1:0] XFER_VERIFY = 2'h0;
	localparam logic [1:0] XFER_WRITE = 2'h1;
	localparam logic [1:0] XFER_READ = 2'h2;
	// dma clock select: 0 = 4 MHz, 1 = 8 MHz, 2 = 25 MHz (tick on every system clock)
	localparam logic [1:0] CLK_SEL_4 = 2'h0;
	localparam logic [1:0] CLK_SEL_8 = 2'h1;
	localparam logic [1:0] CLK_SEL_16 = 2'h2;
	localparam int SYS_CLK_HZ = 25_000_000;
	// ==========================================================
	// wait states per isa dma cycle
	localparam logic [1:0] WAIT_READ = 2'h1;
	localparam logic [1:0] WAIT_WRITE = 2'h2;
	// pc card request source field values
	localparam logic [3:0] PCC_SRC_BVD2 = 4'h0;
	// reset states
	localparam logic [NUM_CH-1:0] MASK_RESET = 8'hff;
	typedef enum logic [2:0] {PDD_IDLE, PDD_HOLD, PDD_FIRST, PDD_SECOND, PDD_DONE} pdd_state_t;
endpackage : pdd_pkg

// ---- rtl/pdd_dma.sv ----
// pdd_dma: seven-channel fly-by dma engine, slave 8-bit channels 0..3,
// master 16-bit channels 5..7, channel 4 cascade only.
// assumes the cpu hold handshake and command strobes are qualified outside.
//
// Notes on behaviour
// [RL1] seven channels, four narrow, three wide
// [RL2] channel four cascades only, never moves data
// [RL3] dma pins share pins via mux select
// [RL4] pc card request from wp or bvd2
// [RL5] fly-by only, no memory to memory
// [RL6] dma clock 4/8/16 MHz by config only; the 16 MHz select ticks on every 25 MHz system clock
// [RL7] narrow address: counter, page, extended page
// [RL8] wide address: a0 zero, counter shifted one
// [RL9] initiator is always an io device
// [RL10] only dram, isa, pc card targets allowed
// [RL11] software keeps target mapping stable
// [RL12] software never pairs wide initiator narrow target
// [RL13] io and memory command together with aen
// [RL14] read: memory read then io write
// [RL15] write: io read then memory write
// [RL16] one wait read, two wait write
// [RL17] single mode: one transfer per acknowledge
// [RL18] demand mode: run while request held
// [RL19] block mode: run to terminal count
// [RL20] software never uses block mode for infrared
// [RL21] autoinitialize reloads current from base
// [RL22] software picks fast clock only if tolerated
// [RL23] transfers equal programmed count plus one
// [RL24] masked channel requests ignored
// [RL25] fixed or rotating priority, channel zero first
// [RL26] terminal count pulse and status bit
`timescale 1ns/10ps
module pdd_dma #(
	parameter int NUM_CH = pdd_pkg::NUM_CH
) (
	input wire logic clk_sys_i,
	input wire logic resetn_i,
	input wire logic ce_i,
	input wire logic [NUM_CH-1:0] dreq_i,
	input wire logic ext_dma_req_a_i,
	input wire logic ext_dma_req_b_i,
	input wire logic [1:0] wp_i,
	input wire logic [1:0] bvd2_i,
	input wire logic [3:0] pcc_req_src_i,
	input wire logic pin_mux_a_i,
	input wire logic pin_mux_b_i,
	input wire logic [1:0] clk_sel_i,
	input wire logic rotate_i,
	input wire logic [NUM_CH-1:0] mask_set_i,
	input wire logic [NUM_CH-1:0] mask_clr_i,
	input wire logic [2:0] cfg_ch_i,
	input wire logic cfg_we_i,
	input wire logic [1:0] cfg_mode_i,
	input wire logic [1:0] cfg_xfer_i,
	input wire logic cfg_auto_i,
	input wire logic [pdd_pkg::CNT_W-1:0] cfg_addr_i,
	input wire logic [pdd_pkg::CNT_W-1:0] cfg_count_i,
	input wire logic [pdd_pkg::PAGE_W-1:0] cfg_page_i,
	input wire logic [pdd_pkg::EXT_W-1:0] cfg_ext_i,
	input wire logic tc_clr_i,
	input wire logic hlda_i,
	input wire logic target_ok_i,
	input wire logic ready_i,
	output logic hold_o,
	output logic [NUM_CH-1:0] dack_o,
	output logic ext_dma_ack_a_o,
	output logic ext_dma_ack_b_o,
	output logic shared_gp_select_11_o,
	output logic shared_gp_select_9_o,
	output logic [pdd_pkg::ADDR_W-1:0] addr_o,
	output logic wide_o,
	output logic ior_o,
	output logic iow_o,
	output logic memr_o,
	output logic memw_o,
	output logic aen_o,
	output logic tc_o,
	output logic [NUM_CH-1:0] tc_status_o,
	output logic [NUM_CH-1:0] mask_o,
	output logic dma_tick_o
);
	localparam int CW = pdd_pkg::CNT_W;
	// ==========================================================
	// synchronisers for pin inputs
	logic [NUM_CH-1:0] req_s1, req_s2;
	logic [5:0] pin_s1, pin_s2;
	always_ff @(posedge clk_sys_i) begin
		if (!resetn_i) begin
			req_s1 <= '0;
			req_s2 <= '0;
			pin_s1 <= '0;
			pin_s2 <= '0;
		end else if (ce_i) begin
			req_s1 <= dreq_i;
			req_s2 <= req_s1;
			pin_s1 <= {wp_i, bvd2_i, ext_dma_req_b_i, ext_dma_req_a_i};
			pin_s2 <= pin_s1;
		end
	end
	// [RL3] pin mux selects dma use
	wire ext_a = pin_s2[0] & pin_mux_a_i;
	wire ext_b = pin_s2[1] & pin_mux_b_i;
	// [RL4] pc card request source select
	wire [1:0] pcc_req = (pcc_req_src_i == pdd_pkg::PCC_SRC_BVD2) ? pin_s2[3:2] : pin_s2[5:4];
	// [RL9] requests only from io-side pins
	// external a,b fixed to 0,1, pc card sockets to 2,3; others direct
	wire [NUM_CH-1:0] raw_req = req_s2 | {{(NUM_CH-4){1'b0}}, pcc_req, ext_b, ext_a};
	// ==========================================================
	// [RL6] dma tick from config select only
	logic [2:0] div_cnt;
	wire [2:0] div_top = (clk_sel_i == pdd_pkg::CLK_SEL_16) ? 3'h0 :
		(clk_sel_i == pdd_pkg::CLK_SEL_8) ? 3'h2 : 3'h5;
	wire tick = (div_cnt >= div_top);
	always_ff @(posedge clk_sys_i) begin
		if (!resetn_i) begin
			div_cnt <= '0;
			dma_tick_o <= 1'b0;
		end else if (ce_i) begin
			div_cnt <= tick ? 3'h0 : div_cnt + 3'h1;
			dma_tick_o <= tick;
		end
	end
	// ==========================================================
	// per-channel programming
	logic [CW-1:0] base_addr [NUM_CH];
	logic [CW-1:0] base_cnt [NUM_CH];
	logic [CW-1:0] cur_addr [NUM_CH];
	logic [CW-1:0] cur_cnt [NUM_CH];
	logic [pdd_pkg::PAGE_W-1:0] page [NUM_CH];
	logic [pdd_pkg::EXT_W-1:0] ext [NUM_CH];
	logic [1:0] mode [NUM_CH];
	logic [1:0] xfer [NUM_CH];
	logic [NUM_CH-1:0] auto_en;
	logic [NUM_CH-1:0] mask;
	logic [2:0] act_ch;
	logic [2:0] last_ch;
	pdd_pkg::pdd_state_t state;
	logic [1:0] wait_cnt;
	wire xfer_end = (state == pdd_pkg::PDD_SECOND) && (wait_cnt == 2'h0) && ready_i && tick;
	wire last_one = (cur_cnt[act_ch] == '0);
	// [RL24] masked channels never request; [RL2] cascade channel never serviced
	wire [NUM_CH-1:0] eligible = raw_req & ~mask & ~(NUM_CH'(1) << pdd_pkg::CASCADE_CH);
	// [RL25] priority pick, rotating starts after last serviced
	function automatic logic [3:0] pick(input logic [NUM_CH-1:0] r, input logic [2:0] start);
		logic [3:0] res;
		logic [2:0] c;
		res = 4'h8;
		for (int i = NUM_CH - 1; i >= 0; i--) begin
			c = start + 3'(i);
			if (r[c]) res = {1'b0, c};
		end
		return res;
	endfunction : pick
	wire [3:0] winner = pick(eligible, rotate_i ? last_ch + 3'h1 : 3'h0);
	genvar g;
	generate
		for (g = 0; g < NUM_CH; g++) begin : g_ch
			wire done_here = xfer_end && (act_ch == 3'(g));
			always_ff @(posedge clk_sys_i) begin
				if (!resetn_i) begin
					base_addr[g] <= '0;
					base_cnt[g] <= '0;
					cur_addr[g] <= '0;
					cur_cnt[g] <= '0;
					page[g] <= '0;
					ext[g] <= '0;
					mode[g] <= pdd_pkg::MODE_DEMAND;
					xfer[g] <= pdd_pkg::XFER_VERIFY;
					auto_en[g] <= 1'b0;
				end else if (ce_i) begin
					if (cfg_we_i && cfg_ch_i == 3'(g)) begin
						base_addr[g] <= cfg_addr_i;
						base_cnt[g] <= cfg_count_i;
						cur_addr[g] <= cfg_addr_i;
						cur_cnt[g] <= cfg_count_i;
						page[g] <= cfg_page_i;
						ext[g] <= cfg_ext_i;
						mode[g] <= cfg_mode_i;
						xfer[g] <= cfg_xfer_i;
						auto_en[g] <= cfg_auto_i;
					end else if (done_here && cur_cnt[g] == '0 && auto_en[g]) begin
						// [RL21] reload from base
						cur_addr[g] <= base_addr[g];
						cur_cnt[g] <= base_cnt[g];
					end else if (done_here) begin
						// [RL23] count down through zero
						cur_addr[g] <= cur_addr[g] + CW'(1);
						cur_cnt[g] <= cur_cnt[g] - CW'(1);
					end
				end
			end
		end
	endgenerate
	// ==========================================================
	// mask and terminal count status
	wire tc_event = xfer_end && last_one;
	always_ff @(posedge clk_sys_i) begin
		if (!resetn_i) begin
			mask <= pdd_pkg::MASK_RESET;
			tc_status_o <= '0;
		end else if (ce_i) begin
			// [RL24] mask set and clear
			mask <= (mask & ~mask_clr_i) | mask_set_i | (tc_event && !auto_en[act_ch] ? NUM_CH'(1) << act_ch : '0);
			// [RL26] tc status, set wins over clear
			tc_status_o <= (tc_status_o & ~{NUM_CH{tc_clr_i}}) | (tc_event ? NUM_CH'(1) << act_ch : '0);
		end
	end
	// ==========================================================
	// transfer sequencer
	// [RL17] [RL18] [RL19] continue decision per mode
	wire go_on = !last_one && (mode[act_ch] == pdd_pkg::MODE_BLOCK ||
		(mode[act_ch] == pdd_pkg::MODE_DEMAND && raw_req[act_ch] && !mask[act_ch]));
	wire is_read = (xfer[act_ch] == pdd_pkg::XFER_READ);
	wire is_write = (xfer[act_ch] == pdd_pkg::XFER_WRITE);
	// [RL1] channels above cascade are wide
	wire wide_ch = (act_ch >= 3'(pdd_pkg::FIRST_WIDE_CH));
	// [RL7] [RL8] address formation
	wire [pdd_pkg::ADDR_W-1:0] next_addr = wide_ch ?
		{ext[act_ch], page[act_ch][7:1], cur_addr[act_ch], 1'b0} :
		{ext[act_ch], page[act_ch], cur_addr[act_ch]};
	always_ff @(posedge clk_sys_i) begin
		if (!resetn_i) begin
			state <= pdd_pkg::PDD_IDLE;
			act_ch <= '0;
			last_ch <= 3'h7;
			wait_cnt <= '0;
		end else if (ce_i) begin
			case (state)
				pdd_pkg::PDD_IDLE: if (!winner[3] && !hlda_i) begin
					act_ch <= winner[2:0];
					state <= pdd_pkg::PDD_HOLD;
				end
				// [RL10] start only toward an allowed target
				pdd_pkg::PDD_HOLD: if (hlda_i && tick && target_ok_i) begin
					// [RL16] wait states by direction
					wait_cnt <= is_read ? pdd_pkg::WAIT_READ : pdd_pkg::WAIT_WRITE;
					state <= pdd_pkg::PDD_FIRST;
				end
				pdd_pkg::PDD_FIRST: if (tick) state <= pdd_pkg::PDD_SECOND;
				pdd_pkg::PDD_SECOND: if (tick && wait_cnt != 2'h0) begin
					wait_cnt <= wait_cnt - 2'h1;
				end else if (xfer_end) begin
					state <= go_on ? pdd_pkg::PDD_FIRST : pdd_pkg::PDD_DONE;
					wait_cnt <= is_read ? pdd_pkg::WAIT_READ : pdd_pkg::WAIT_WRITE;
					if (!go_on) last_ch <= act_ch;
				end
				// hold drops until hlda is released before a new service
				pdd_pkg::PDD_DONE: if (!hlda_i) state <= pdd_pkg::PDD_IDLE;
				default: state <= pdd_pkg::PDD_IDLE;
			endcase
		end
	end
	// ==========================================================
	// registered bus outputs
	wire in_xfer = (state == pdd_pkg::PDD_FIRST) || (state == pdd_pkg::PDD_SECOND);
	wire [NUM_CH-1:0] next_dack = in_xfer ? NUM_CH'(1) << act_ch : '0;
	always_ff @(posedge clk_sys_i) begin
		if (!resetn_i) begin
			hold_o <= 1'b0;
			dack_o <= '0;
			ext_dma_ack_a_o <= 1'b0;
			ext_dma_ack_b_o <= 1'b0;
			shared_gp_select_11_o <= 1'b0;
			shared_gp_select_9_o <= 1'b0;
			addr_o <= '0;
			wide_o <= 1'b0;
			ior_o <= 1'b0;
			iow_o <= 1'b0;
			memr_o <= 1'b0;
			memw_o <= 1'b0;
			aen_o <= 1'b0;
			tc_o <= 1'b0;
			mask_o <= pdd_pkg::MASK_RESET;
		end else if (ce_i) begin
			hold_o <= (state == pdd_pkg::PDD_HOLD) || in_xfer;
			dack_o <= next_dack;
			ext_dma_ack_a_o <= next_dack[0] & pin_mux_a_i;
			ext_dma_ack_b_o <= next_dack[1] & pin_mux_b_i;
			// [RL3] shared pins carry tc and ack when muxed
			shared_gp_select_11_o <= next_dack[0] & pin_mux_a_i;
			shared_gp_select_9_o <= in_xfer & last_one & pin_mux_a_i;
			addr_o <= in_xfer ? next_addr : '0;
			wide_o <= in_xfer & wide_ch;
			// [RL5] [RL13] [RL14] [RL15] fly-by strobes, io and memory together
			memr_o <= in_xfer & is_read;
			iow_o <= (state == pdd_pkg::PDD_SECOND) & is_read;
			ior_o <= in_xfer & is_write;
			memw_o <= (state == pdd_pkg::PDD_SECOND) & is_write;
			aen_o <= in_xfer;
			// [RL26] tc during final transfer
			tc_o <= in_xfer & last_one;
			mask_o <= mask;
		end
	end
	// ==========================================================
	// checks
	// a_cascade_no_ack: cascade never acknowledged // [RL2]
	a_cascade_no_ack: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		!dack_o[pdd_pkg::CASCADE_CH]) else $error("cascade channel acknowledged");
	a_aen_with_cmd: assert property (@(posedge clk_sys_i) disable iff (!resetn_i) // [RL13]
		(memr_o | memw_o | ior_o | iow_o) |-> aen_o) else $error("command without aen");
	a_wide_a0_zero: assert property (@(posedge clk_sys_i) disable iff (!resetn_i) // [RL8]
		wide_o |-> !addr_o[0]) else $error("wide address odd");
	a_masked_no_ack: assert property (@(posedge clk_sys_i) disable iff (!resetn_i) // [RL24]
		(ce_i && state == pdd_pkg::PDD_IDLE && !winner[3] && !hlda_i) |-> !mask[winner[2:0]])
		else $error("masked channel granted");
	a_no_mem2mem: assert property (@(posedge clk_sys_i) disable iff (!resetn_i) // [RL5]
		!(memr_o && memw_o) && !(ior_o && iow_o)) else $error("non fly-by strobes");
	a_tc_sets_stat: assert property (@(posedge clk_sys_i) disable iff (!resetn_i) // [RL26]
		(ce_i && tc_event) |=> tc_status_o[$past(act_ch)]) else $error("tc status missing");
	a_auto_reload: assert property (@(posedge clk_sys_i) disable iff (!resetn_i) // [RL21]
		(ce_i && tc_event && auto_en[act_ch] && !cfg_we_i) |=> cur_cnt[$past(act_ch)] == base_cnt[$past(act_ch)])
		else $error("autoinit reload missing");
	a_count_step: assert property (@(posedge clk_sys_i) disable iff (!resetn_i) // [RL23]
		(ce_i && xfer_end && !last_one && !cfg_we_i) |=> cur_cnt[$past(act_ch)] == $past(cur_cnt[act_ch]) - CW'(1))
		else $error("count did not step");
	c_block_run: cover property (@(posedge clk_sys_i) state == pdd_pkg::PDD_SECOND ##1 state == pdd_pkg::PDD_FIRST);
	c_tc_seen: cover property (@(posedge clk_sys_i) tc_o);
	c_wide_xfer: cover property (@(posedge clk_sys_i) wide_o && memw_o);
endmodule : pdd_dma

// ---- verif/pdd_initiator.sv ----
// pdd_initiator: behavioural io initiator driving one dma request line.
// assumes the bench routes req_o to a request pin and ack_i from that channel's acknowledge.
`timescale 1ns/10ps
module pdd_initiator (
	input wire logic clk_sys_i,
	input wire logic go_i,
	input wire logic demand_i,
	input wire logic [3:0] lim_i,
	input wire logic ack_i,
	input wire logic xfer_i,
	output logic req_o
);
	logic [3:0] done = 4'h0;
	logic was = 1'b0;
	initial req_o = 1'b0;
	// ==========================================================
	// request line, changed off the sampling edge
	always @(negedge clk_sys_i) begin
		was <= xfer_i;
		if (go_i) begin
			req_o <= 1'b1;
			done <= 4'h0;
		end else if (req_o) begin
			if (!demand_i && ack_i)
				req_o <= 1'b0;
			if (demand_i && xfer_i && !was) begin
				done <= done + 4'h1;
				if (done + 4'h1 == lim_i)
					req_o <= 1'b0;
			end
		end
	end
endmodule : pdd_initiator

// ---- verif/pc_at_dual_dma_controller_tb.sv ----
// pc_at_dual_dma_controller_tb: self-checking bench for the fly-by dma engine.
// assumes one 25 MHz clock; the bench plays the cpu hold side, the partner the io side.
// software-side duties (no block mode on infrared, safe clock, no wide initiator on a narrow target) hold by choice of stimulus.
// kept by the stimulus: fixed mapping, matched widths, no infrared, 16 MHz io only.
`timescale 1ns/10ps
module pc_at_dual_dma_controller_tb;
	logic clk_sys_i = 0, resetn_i = 0, hlda_i = 0, cfg_we_i = 0, cfg_auto_i = 0, tc_clr_i = 0;
	logic target_ok_i = 1, go = 0, preq, ea = 0, pf = 0;
	logic [2:0] cfg_ch_i = 0;
	logic [1:0] cfg_mode_i = 0, cfg_xfer_i = 0, cfg_ext_i = 0, clk_sel_i = 2, route = 0;
	logic [15:0] cfg_addr_i = 0, cfg_count_i = 0;
	logic [7:0] cfg_page_i = 0, mask_set_i = 0, mask_clr_i = 0, cdr = 0, dreq_i;
	logic [3:0] lim = 0;
	logic hold_o, ext_dma_ack_a_o, ior_o, iow_o, memr_o, memw_o, aen_o, tc_o, dma_tick_o;
	logic [7:0] dack_o, tc_status_o, mask_o;
	logic [25:0] addr_o, fa;
	int err_total = 0, tests_run = 0, nx, tcn, slen, rlen;
	int exp_d[3] = '{6, 3, 1};
	// ==========================================================
	// design, partner and cpu side
	assign dreq_i = ((route == 2'h0) ? (8'h01 << cfg_ch_i) & {8{preq}} : 8'h00) | cdr;
	pdd_dma dut (.clk_sys_i, .resetn_i, .ce_i(1'b1), .dreq_i, .ext_dma_req_a_i(route == 2'h1 && preq),
		.ext_dma_req_b_i(1'b0), .wp_i({1'b0, route == 2'h2 && preq}), .bvd2_i({1'b0, route == 2'h3 && preq}),
		.pcc_req_src_i((route == 2'h3) ? pdd_pkg::PCC_SRC_BVD2 : 4'h1), .pin_mux_a_i(route == 2'h1),
		.pin_mux_b_i(1'b0), .clk_sel_i, .rotate_i(1'b0), .mask_set_i, .mask_clr_i, .cfg_ch_i, .cfg_we_i,
		.cfg_mode_i, .cfg_xfer_i, .cfg_auto_i, .cfg_addr_i, .cfg_count_i, .cfg_page_i, .cfg_ext_i, .tc_clr_i,
		.hlda_i, .target_ok_i, .ready_i(1'b1), .hold_o, .dack_o, .ext_dma_ack_a_o, .ext_dma_ack_b_o(),
		.shared_gp_select_11_o(), .shared_gp_select_9_o(), .addr_o, .wide_o(), .ior_o, .iow_o, .memr_o,
		.memw_o, .aen_o, .tc_o, .tc_status_o, .mask_o, .dma_tick_o);
	pdd_initiator peer (.clk_sys_i, .go_i(go), .demand_i(cfg_mode_i == pdd_pkg::MODE_DEMAND), .lim_i(lim),
		.ack_i(dack_o[cfg_ch_i]), .xfer_i(iow_o | memw_o), .req_o(preq));
	always #20 clk_sys_i = ~clk_sys_i;
	always @(negedge clk_sys_i) hlda_i <= hold_o;
	// ==========================================================
	// transfer monitor
	always @(posedge clk_sys_i) begin
		// transfers counted on the second strobe, which pulses once per transfer
		pf <= iow_o | memw_o;
		ea |= ext_dma_ack_a_o;
		if ((iow_o | memw_o) && !pf) begin
			nx++;
			slen = 0;
			if (nx == 1)
				fa = addr_o;
		end
		if (tc_o && (iow_o | memw_o) && tcn == 0)
			tcn = nx;
		if (iow_o | memw_o) begin
			slen++;
			chk(aen_o && dack_o != 8'h00 && ((memr_o && iow_o) || (ior_o && memw_o)), "strobes");
		end
	end
	// ==========================================================
	// shared tasks
	task automatic chk(input logic ok, input string msg);
		tests_run++;
		if (ok !== 1'b1) begin
			err_total++;
			$display("FAIL %0t %s", $time, msg);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(negedge clk_sys_i);
	endtask : cyc
	task automatic end_of_test;
		if (err_total == 0 && tests_run > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : end_of_test
	// one service run; prog low reuses the reloaded channel state
	task automatic run(input logic [2:0] ch, input logic [1:0] mode, xfer, src, input logic au, prog,
			input logic [15:0] c, input int exp_n);
		int k;
		logic fin;
		logic [25:0] ea_exp;
		fin = (int'(c) + 1 == exp_n);
		ea_exp = (ch >= pdd_pkg::FIRST_WIDE_CH) ? {2'h2, 7'h2d, 16'h8ff0, 1'b0} : {2'h2, 8'h5b, 16'h8ff0};
		cyc(1);
		route = src;
		if (prog) begin
			cfg_ch_i = ch;
			cfg_mode_i = mode;
			cfg_xfer_i = xfer;
			cfg_auto_i = au;
			cfg_count_i = c;
			cfg_addr_i = 16'h8ff0;
			cfg_page_i = 8'h5b;
			cfg_ext_i = 2'h2;
			cfg_we_i = 1'b1;
			cyc(1);
			cfg_we_i = 1'b0;
		end
		mask_clr_i = 8'h01 << ch;
		nx = 0;
		tcn = 0;
		ea = 1'b0;
		go = 1'b1;
		cyc(1);
		go = 1'b0;
		mask_clr_i = 8'h00;
		k = 0;
		while (dack_o[ch] !== 1'b1 && k < 300) begin
			cyc(1);
			k++;
		end
		while ((hold_o | dack_o[ch]) !== 1'b0 && k < 3000) begin
			cyc(1);
			k++;
		end
		if (k >= 3000) begin
			chk(1'b0, "run hung");
			end_of_test();
		end
		chk(fa === ea_exp, "first address");
		if (exp_n > 0)
			chk(nx == exp_n, "transfer count");
		chk(tcn == (fin ? exp_n : 0), "tc timing");
		chk(tc_status_o[ch] === fin, "tc status");
		chk(mask_o[ch] === (fin && !au), "mask after tc");
	endtask : run
	task automatic no_serv(input logic [7:0] req, clr, input logic tok);
		int k;
		cyc(1);
		cdr = req;
		mask_clr_i = clr;
		target_ok_i = tok;
		for (k = 0; k < 60; k++) begin
			cyc(1);
			chk(dack_o === 8'h00 && (!tok || hold_o === 1'b0), "refused service");
		end
		cdr = 8'h00;
		mask_clr_i = 8'h00;
	endtask : no_serv
	task automatic tick_rate;
		int s, k, d;
		for (s = 0; s < 3; s++) begin
			clk_sel_i = 2'(s);
			cyc(8);
			k = 0;
			while (dma_tick_o !== 1'b1 && k < 20) begin
				cyc(1);
				k++;
			end
			d = 0;
			do begin
				cyc(1);
				d++;
			end while (dma_tick_o !== 1'b1 && d < 20);
			chk(d == exp_d[s], "tick spacing");
		end
	endtask : tick_rate
	// ==========================================================
	// main sequence
	initial begin
		cyc(4);
		resetn_i = 1'b1;
		cyc(1);
		chk(mask_o === 8'hff && hold_o === 1'b0 && tc_status_o === 8'h00, "reset state");
		tick_rate();
		run(3'd0, pdd_pkg::MODE_SINGLE, pdd_pkg::XFER_READ, 2'h1, 1'b0, 1'b1, 16'h0003, 1);
		chk(ea === 1'b1, "external ack");
		rlen = slen;
		run(3'd5, pdd_pkg::MODE_BLOCK, pdd_pkg::XFER_WRITE, 2'h0, 1'b0, 1'b1, 16'h0002, 3);
		chk(slen == rlen + 1, "write wait states");
		lim = 4'h2;
		run(3'd2, pdd_pkg::MODE_DEMAND, pdd_pkg::XFER_WRITE, 2'h2, 1'b0, 1'b1, 16'h0007, 0);
		chk(nx >= 2 && nx < 8, "demand stop");
		run(3'd2, pdd_pkg::MODE_SINGLE, pdd_pkg::XFER_READ, 2'h3, 1'b1, 1'b1, 16'h0000, 1);
		run(3'd2, pdd_pkg::MODE_SINGLE, pdd_pkg::XFER_READ, 2'h3, 1'b1, 1'b0, 16'h0000, 1);
		no_serv(8'h02, 8'h00, 1'b1);
		no_serv(8'h10, 8'h10, 1'b1);
		tc_clr_i = 1'b1;
		cyc(1);
		tc_clr_i = 1'b0;
		cyc(1);
		chk(tc_status_o === 8'h00, "tc clear");
		no_serv(8'h02, 8'h02, 1'b0);
		end_of_test();
	end
endmodule : pc_at_dual_dma_controller_tb
